/* File: verilog/cpsc_top.sv */
// Status and cause registers of the system coprocessor, with AXI4-Lite access
`timescale 1ns/10ps
`default_nettype none
module cpsc_top #(
  parameter logic [31:0] NORMAL_BASE = 32'h0000_0000,
  parameter logic [31:0] BOOT_BASE = 32'h0000_1000
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic exc_valid,
  input wire logic [4:0] exc_code_in,
  input wire logic exc_in_delay_slot,
  input wire logic [1:0] exc_cop_num,
  input wire logic exc_return,
  input wire logic soft_reset_evt,
  input wire logic nmi_evt,
  input wire logic tlb_multi_match,
  input wire logic [1:0] miss_space,
  input wire logic [4:0] hw_int_pins,
  output logic mode_user,
  output logic mode_super,
  output logic mode_kernel,
  output logic cp0_usable,
  output logic kseg_ok,
  output logic sseg_ok,
  output logic useg_ok,
  output logic wide_addr_ok,
  output logic wide_ops_ok,
  output logic xtlb_refill,
  output logic irq_take,
  output logic [7:0] irq_pending,
  output logic tlb_disabled,
  output logic [31:0] vector_base
);
  typedef struct packed {
    logic [31:0] status;
    logic slot;
    logic [1:0] ce;
    logic pend_tmr;
    logic [1:0] pend_sw;
    logic [4:0] exc;
    logic [31:0] count;
    logic [31:0] compare;
    logic [4:0] hw_s1;
    logic [4:0] hw_s2;
  } cpsc_regs_t;

  localparam cpsc_regs_t REGS_RST = '{
    status: cpsc_pkg::STATUS_RST,
    default: '0
  };

  cpsc_regs_t q, d;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] cause_rd;
  logic [4:0] hw_live;
  logic [7:0] irq_mask;
  logic timer_match;
  logic cmp_wr;
  logic [31:0] cause_wr;

  // Known offsets; anything else is answered with an error
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == cpsc_pkg::OFF_STATUS) || (a == cpsc_pkg::OFF_CAUSE) ||
             (a == cpsc_pkg::OFF_COMPARE) || (a == cpsc_pkg::OFF_COUNT);
  endfunction : mapped

  cpsc_axil u_axil (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(!mapped(wr_addr)),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(!mapped(rd_addr))
  );

  cpsc_mode_dec u_mode (
    .priv_mode_field(q.status[cpsc_pkg::ST_PRIV_LO +: 2]),
    .exception_level(q.status[cpsc_pkg::ST_EXC_LVL]),
    .error_level(q.status[cpsc_pkg::ST_ERR_LVL]),
    .coproc0_user_enable(q.status[cpsc_pkg::ST_COP0_EN]),
    .kernel_wide_addr(q.status[cpsc_pkg::ST_K_WIDE]),
    .super_wide_addr(q.status[cpsc_pkg::ST_S_WIDE]),
    .user_wide_addr(q.status[cpsc_pkg::ST_U_WIDE]),
    .miss_space(miss_space),
    .mode_user(mode_user),
    .mode_super(mode_super),
    .mode_kernel(mode_kernel),
    .cp0_usable(cp0_usable),
    .kseg_ok(kseg_ok),
    .sseg_ok(sseg_ok),
    .useg_ok(useg_ok),
    .wide_addr_ok(wide_addr_ok),
    .wide_ops_ok(wide_ops_ok),
    .xtlb_refill(xtlb_refill)
  );

  // Synchronised inputs; the top input is tied off as it never fires
  always_comb begin
    hw_live = q.hw_s2;
    hw_live[cpsc_pkg::HW_INT_DEAD] = 1'b0;
  end

  // Pending vector: timer on top, inputs, then software bits
  assign irq_pending = {q.pend_tmr, hw_live, q.pend_sw};
  assign irq_mask = q.status[cpsc_pkg::ST_MASK_LO +: 8];

  // Taken only with enable set and both levels clear
  assign irq_take = q.status[cpsc_pkg::ST_GIE] &&
                    !q.status[cpsc_pkg::ST_EXC_LVL] &&
                    !q.status[cpsc_pkg::ST_ERR_LVL] &&
                    |(irq_pending & irq_mask);

  // Shutdown flag disables the TLB until the next cold reset
  assign tlb_disabled = q.status[cpsc_pkg::ST_TLB_SHUT];
  assign vector_base = q.status[cpsc_pkg::ST_BOOT_VEC] ? BOOT_BASE
    : NORMAL_BASE;

  // Cause image; unlisted bits stay zero
  always_comb begin
    cause_rd = '0;
    cause_rd[cpsc_pkg::CA_SLOT] = q.slot;
    cause_rd[cpsc_pkg::CA_CE_LO +: 2] = q.ce;
    cause_rd[cpsc_pkg::CA_PEND_LO +: 8] = irq_pending;
    cause_rd[cpsc_pkg::CA_EXC_LO +: 5] = q.exc;
  end

  // Read mux, captured by the bus front end on the address handshake
  always_comb begin
    case (rd_addr)
      cpsc_pkg::OFF_STATUS: rd_data = q.status;
      cpsc_pkg::OFF_CAUSE: rd_data = cause_rd;
      cpsc_pkg::OFF_COMPARE: rd_data = q.compare;
      cpsc_pkg::OFF_COUNT: rd_data = q.count;
      default: rd_data = '0;
    endcase
  end

  assign timer_match = (q.count == q.compare);
  assign cmp_wr = wr_en && (wr_addr == cpsc_pkg::OFF_COMPARE);
  // Software write merged into the pending image; a call result cannot
  // be sliced directly, so it lands in a net first
  assign cause_wr = cpsc_pkg::merge({22'h0, q.pend_sw, 8'h00}, wr_data,
                                    wr_strb, cpsc_pkg::CA_WMASK);

  // Next state: software writes first, hardware events override after
  always_comb begin
    d = q;
    d.hw_s1 = hw_int_pins;
    d.hw_s2 = q.hw_s1;
    d.count = q.count + 32'h0000_0001;
    if (wr_en && (wr_addr == cpsc_pkg::OFF_STATUS)) begin
      // Mask keeps shutdown and reserved bits out of reach
      d.status = cpsc_pkg::merge(q.status, wr_data, wr_strb,
                                 cpsc_pkg::ST_WMASK);
    end
    if (wr_en && (wr_addr == cpsc_pkg::OFF_CAUSE)) begin
      // Only the software pendings take a write
      d.pend_sw = cause_wr[cpsc_pkg::CA_PEND_LO +: 2];
    end
    if (cmp_wr) begin
      d.compare = cpsc_pkg::merge(q.compare, wr_data, wr_strb,
                                  32'hFFFF_FFFF);
      d.pend_tmr = 1'b0;
    end
    if (wr_en && (wr_addr == cpsc_pkg::OFF_COUNT)) begin
      d.count = cpsc_pkg::merge(q.count, wr_data, wr_strb, 32'hFFFF_FFFF);
    end
    // A match in the clearing cycle still sets the request
    if (timer_match) begin
      d.pend_tmr = 1'b1;
    end
    if (tlb_multi_match) begin
      d.status[cpsc_pkg::ST_TLB_SHUT] = 1'b1;
    end
    // Return drops the error level first, else the exception level
    if (exc_return) begin
      if (q.status[cpsc_pkg::ST_ERR_LVL]) begin
        d.status[cpsc_pkg::ST_ERR_LVL] = 1'b0;
      end else begin
        d.status[cpsc_pkg::ST_EXC_LVL] = 1'b0;
      end
    end
    // Cause fields recorded together with the entry
    if (exc_valid) begin
      d.status[cpsc_pkg::ST_EXC_LVL] = 1'b1;
      d.exc = exc_code_in;
      d.slot = exc_in_delay_slot;
      if (exc_code_in == cpsc_pkg::EXC_CPU) begin
        d.ce = exc_cop_num;
      end
    end
    // Soft reset and NMI mark the flag and enter error level
    if (soft_reset_evt || nmi_evt) begin
      d.status[cpsc_pkg::ST_SOFT_RST] = 1'b1;
      d.status[cpsc_pkg::ST_ERR_LVL] = 1'b1;
      d.status[cpsc_pkg::ST_BOOT_VEC] = 1'b1;
    end
  end

  // Cold reset clears both flags, sets error level and boot vectors
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= REGS_RST;
    end else begin
      q <= d;
    end
  end

  // Checks on the register behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_kern_levels;
    (q.status[cpsc_pkg::ST_EXC_LVL] || q.status[cpsc_pkg::ST_ERR_LVL]) |->
      (mode_kernel && !mode_user && !mode_super && !irq_take);
  endproperty
  a_kern_levels: assert property (p_kern_levels)
    else $error("levels set but not in kernel mode");

  property p_mask_gate;
    ((irq_pending & irq_mask) == 8'h00) |-> !irq_take;
  endproperty
  a_mask_gate: assert property (p_mask_gate)
    else $error("interrupt taken with every source masked");

  property p_cp0_gate;
    (!mode_kernel && !q.status[cpsc_pkg::ST_COP0_EN]) |-> !cp0_usable;
  endproperty
  a_cp0_gate: assert property (p_cp0_gate)
    else $error("coprocessor 0 usable outside kernel without enable");

  property p_shut_sticky;
    tlb_disabled |=> tlb_disabled [*8];
  endproperty
  a_shut_sticky: assert property (p_shut_sticky)
    else $error("shutdown flag dropped without reset");

  property p_shut_set;
    tlb_multi_match |=> tlb_disabled;
  endproperty
  a_shut_set: assert property (p_shut_set)
    else $error("multiple match did not shut the TLB down");

  property p_softrst_set;
    (soft_reset_evt || nmi_evt) |=>
      (q.status[cpsc_pkg::ST_SOFT_RST] && q.status[cpsc_pkg::ST_ERR_LVL]);
  endproperty
  a_softrst_set: assert property (p_softrst_set)
    else $error("soft reset or NMI did not set the flag");

  property p_exc_entry;
    exc_valid |=> (q.exc == $past(exc_code_in)) &&
                  (q.slot == $past(exc_in_delay_slot)) &&
                  q.status[cpsc_pkg::ST_EXC_LVL];
  endproperty
  a_exc_entry: assert property (p_exc_entry)
    else $error("cause fields not recorded on exception entry");

  property p_ce_hold;
    (exc_valid && (exc_code_in != cpsc_pkg::EXC_CPU)) |=>
      (q.ce == $past(q.ce));
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("coprocessor number changed by another exception");

  property p_cause_ro;
    (wr_en && (wr_addr == cpsc_pkg::OFF_CAUSE) && !exc_valid) |=>
      (q.exc == $past(q.exc)) && (q.slot == $past(q.slot));
  endproperty
  a_cause_ro: assert property (p_cause_ro)
    else $error("software write altered a read-only cause field");

  property p_timer_set;
    timer_match |=> q.pend_tmr;
  endproperty
  a_timer_set: assert property (p_timer_set)
    else $error("count match did not raise the timer request");

  property p_timer_clr;
    (cmp_wr && !timer_match) |=> !q.pend_tmr;
  endproperty
  a_timer_clr: assert property (p_timer_clr)
    else $error("compare write did not clear the timer request");

  property p_resv_zero;
    (q.status[31:29] == 3'h0) && (q.status[27:26] == 2'h0) &&
      (q.status[24:23] == 2'h0) && (q.status[19] == 1'b0) &&
      (cause_rd[30] == 1'b0) && (cause_rd[7] == 1'b0) &&
      (cause_rd[1:0] == 2'h0) && (irq_pending[6] == 1'b0);
  endproperty
  a_resv_zero: assert property (p_resv_zero)
    else $error("reserved bit reads as one");

  c_irq_taken: cover property (irq_take ##1 exc_valid);
  c_cpu_exc: cover property (exc_valid && (exc_code_in == cpsc_pkg::EXC_CPU));
  c_timer: cover property (cmp_wr ##[1:20] q.pend_tmr);
  c_shutdown: cover property (tlb_multi_match ##1 tlb_disabled);
endmodule : cpsc_top
`default_nettype wire

/* File: verilog/cpsc_pkg.sv */
// Constants, field layouts and helpers for the status and cause registers
package cpsc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CAUSE = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0C;
  // Status field positions
  localparam int ST_COP0_EN = 28;
  localparam int ST_SWAP_USR = 25;
  localparam int ST_BOOT_VEC = 22;
  localparam int ST_TLB_SHUT = 21;
  localparam int ST_SOFT_RST = 20;
  localparam int ST_COND = 18;
  localparam int ST_MASK_LO = 8;
  localparam int ST_K_WIDE = 7;
  localparam int ST_S_WIDE = 6;
  localparam int ST_U_WIDE = 5;
  localparam int ST_PRIV_LO = 3;
  localparam int ST_ERR_LVL = 2;
  localparam int ST_EXC_LVL = 1;
  localparam int ST_GIE = 0;
  localparam logic [31:0] ST_WMASK = 32'h1257_FFFF;
  localparam logic [31:0] STATUS_RST = 32'h0040_0004;
  // Cause field positions
  localparam int CA_SLOT = 31;
  localparam int CA_CE_LO = 28;
  localparam int CA_PEND_LO = 8;
  localparam int CA_EXC_LO = 2;
  localparam logic [31:0] CA_WMASK = 32'h0000_0300;
  localparam int HW_INT_W = 5;
  localparam int HW_INT_DEAD = 4;
  localparam logic [1:0] PRIV_USER = 2'h2;
  localparam logic [1:0] PRIV_SUPER = 2'h1;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] SPACE_USER = 2'h0;
  localparam logic [1:0] SPACE_SUPER = 2'h1;
  localparam logic [1:0] SPACE_KERNEL = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    EXC_INT = 5'h00, EXC_MOD = 5'h01, EXC_TLBL = 5'h02, EXC_TLBS = 5'h03,
    EXC_ADEL = 5'h04, EXC_ADES = 5'h05, EXC_IBE = 5'h06, EXC_DBE = 5'h07,
    EXC_SYS = 5'h08, EXC_BP = 5'h09, EXC_RI = 5'h0A, EXC_CPU = 5'h0B,
    EXC_OV = 5'h0C, EXC_TR = 5'h0D
  } cpsc_exc_t;
  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask
  // Merge of a strobed write into the writable bits only
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] s, input logic [31:0] wm);
    logic [31:0] m;
    m = strb_mask(s) & wm;
    merge = (old & ~m) | (wd & m);
  endfunction : merge
endpackage : cpsc_pkg

/* File: verilog/cpsc_axil.sv */
// AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/10ps
`default_nettype none
module cpsc_axil (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cpsc_axi_st_t;
  cpsc_axi_st_t q, d;

  // Channels refuse new items while a response is still owed
  assign awready = !q.aw_full && !q.bvalid;
  assign wready = !q.w_full && !q.bvalid;
  assign arready = !q.rvalid;
  assign wr_en = q.aw_full && q.w_full && !q.bvalid;
  assign wr_addr = q.aw_addr;
  assign wr_data = q.w_data;
  assign wr_strb = q.w_strb;
  assign rd_en = arvalid && arready;
  assign rd_addr = araddr;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;

  // Next state of the channel holders
  always_comb begin
    d = q;
    if (awvalid && awready) begin
      d.aw_full = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      d.w_full = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (wr_en) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_err ? cpsc_pkg::RESP_SLVERR : cpsc_pkg::RESP_OKAY;
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (rd_en) begin
      d.rvalid = 1'b1;
      d.rdata = rd_data;
      d.rresp = rd_err ? cpsc_pkg::RESP_SLVERR : cpsc_pkg::RESP_OKAY;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : cpsc_axil
`default_nettype wire

/* File: verilog/cpsc_mode_dec.sv */
// Operating mode, privilege and address-width decode
`timescale 1ns/10ps
`default_nettype none
module cpsc_mode_dec (
  input wire logic [1:0] priv_mode_field,
  input wire logic exception_level,
  input wire logic error_level,
  input wire logic coproc0_user_enable,
  input wire logic kernel_wide_addr,
  input wire logic super_wide_addr,
  input wire logic user_wide_addr,
  input wire logic [1:0] miss_space,
  output logic mode_user,
  output logic mode_super,
  output logic mode_kernel,
  output logic cp0_usable,
  output logic kseg_ok,
  output logic sseg_ok,
  output logic useg_ok,
  output logic wide_addr_ok,
  output logic wide_ops_ok,
  output logic xtlb_refill
);
  logic lvl;
  assign lvl = exception_level || error_level;
  // Either level forces kernel; field 11 also falls to kernel
  assign mode_user = !lvl && (priv_mode_field == cpsc_pkg::PRIV_USER);
  assign mode_super = !lvl && (priv_mode_field == cpsc_pkg::PRIV_SUPER);
  assign mode_kernel = !mode_user && !mode_super;
  assign cp0_usable = mode_kernel || coproc0_user_enable;
  // Space permissions by mode
  assign kseg_ok = mode_kernel;
  assign sseg_ok = mode_kernel || mode_super;
  assign useg_ok = 1'b1;
  // Width per mode
  assign wide_addr_ok = (mode_kernel && kernel_wide_addr) ||
                        (mode_super && super_wide_addr) ||
                        (mode_user && user_wide_addr);
  assign wide_ops_ok = mode_kernel || (mode_super && super_wide_addr) ||
                       (mode_user && user_wide_addr);
  // Extended refill chosen by the missing space's wide bit
  always_comb begin
    case (miss_space)
      cpsc_pkg::SPACE_KERNEL: xtlb_refill = kernel_wide_addr;
      cpsc_pkg::SPACE_SUPER: xtlb_refill = super_wide_addr;
      cpsc_pkg::SPACE_USER: xtlb_refill = user_wide_addr;
      default: xtlb_refill = 1'b0;
    endcase
  end
endmodule : cpsc_mode_dec
`default_nettype wire

/* File: verification/cp0_status_cause_regs_tb.sv */
// Self-checking bench for the status and cause register block
`timescale 1ns/10ps
`default_nettype none
module cp0_status_cause_regs_tb;
  localparam logic [31:0] NB = 32'h0000_0000;
  localparam logic [31:0] BB = 32'h0000_1000;
  localparam logic [7:0] AS = cpsc_pkg::OFF_STATUS;
  localparam logic [7:0] AC = cpsc_pkg::OFF_CAUSE;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1, exc_valid = 1'b0;
  logic exc_in_delay_slot = 1'b0, exc_return = 1'b0, nmi_evt = 1'b0;
  logic soft_reset_evt = 1'b0, tlb_multi_match = 1'b0;
  logic [4:0] exc_code_in = 5'h00, hw_int_pins = 5'h00;
  logic [1:0] exc_cop_num = 2'h0, miss_space = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, mode_user, mode_super;
  logic mode_kernel, cp0_usable, kseg_ok, sseg_ok, useg_ok, wide_addr_ok;
  logic wide_ops_ok, xtlb_refill, irq_take, tlb_disabled;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, vector_base;
  logic [7:0] irq_pending;
  // Reference model state
  logic [31:0] st, seed = 32'h0000_1466;
  logic [4:0] ex;
  logic [1:0] sw, ce;
  logic sl, tp;
  int error_cnt = 0, n_tests = 0;

  cpsc_top #(.NORMAL_BASE(NB), .BOOT_BASE(BB)) dut (.*);

  // Clock, 100 ns period
  always #50 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Strobed merge into the bits software may change
  function automatic logic [31:0] wm(input logic [31:0] o, d,
      input logic [3:0] s, input logic [31:0] m);
    for (int i = 0; i < 4; i++) if (!s[i]) m[i*8+:8] = 8'h00;
    return (o & ~m) | (d & m);
  endfunction : wm

  function automatic logic [31:0] cx();
    return {sl, 1'b0, ce, 12'h000, tp, 1'b0, hw_int_pins[3:0], sw, 1'b0,
      ex, 2'h0};
  endfunction : cx

  task automatic chk(input logic [31:0] g, e, input string m);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic mr();
    st = 32'h0040_0004;
    {sw, ce, ex, sl} = 10'h000;
    tp = 1'b1; // Count and compare both zero out of reset
  endtask : mr

  // Write: both channels offered together, each dropped once taken
  task automatic w(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    logic ka, kw, kb;
    logic [1:0] r;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    kb = 1'b0;
    while (!kb) begin
      @(negedge ref_clk);
      ka = awvalid & awready;
      kw = wvalid & wready;
      kb = bvalid;
      r = bresp;
      @(posedge ref_clk);
      if (ka) awvalid <= 1'b0;
      if (kw) wvalid <= 1'b0;
    end
    chk({30'h0, r}, {30'h0, a > 8'h0C ? 2'h2 : 2'h0}, "bresp");
    if (a == AS) st = wm(st, d, s, cpsc_pkg::ST_WMASK);
    if (a == AC && s[1]) sw = d[9:8];
    if (a == cpsc_pkg::OFF_COMPARE) tp = 1'b0;
  endtask : w

  // Read and compare with the expected word
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic ka, kr;
    logic [31:0] d;
    logic [1:0] r;
    araddr <= a;
    arvalid <= 1'b1;
    kr = 1'b0;
    while (!kr) begin
      @(negedge ref_clk);
      ka = arvalid & arready;
      kr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (ka) arvalid <= 1'b0;
    end
    chk(d, e, "read data");
    chk({30'h0, r}, {30'h0, a > 8'h0C ? 2'h2 : 2'h0}, "rresp");
  endtask : rc

  // One-cycle pulse on the core event inputs
  task automatic ev(input logic [4:0] m);
    {tlb_multi_match, nmi_evt, soft_reset_evt, exc_return, exc_valid} <= m;
    @(posedge ref_clk);
    {tlb_multi_match, nmi_evt, soft_reset_evt, exc_return, exc_valid} <= 5'h00;
  endtask : ev

  // Decoded outputs against the model status word
  task automatic outs();
    logic lv, u, s, k;
    logic [7:0] p;
    @(negedge ref_clk); // Read mid cycle, clear of the launching edge
    lv = st[2] | st[1];
    u = !lv && st[4:3] == 2'h2;
    s = !lv && st[4:3] == 2'h1;
    k = !(u || s);
    p = {tp, 1'b0, hw_int_pins[3:0], sw};
    chk(vector_base, st[22] ? BB : NB, "vector");
    chk({24'h0, irq_pending}, {24'h0, p}, "pending");
    chk({25'h0, mode_user, mode_super, mode_kernel, cp0_usable, kseg_ok,
      sseg_ok, useg_ok}, {25'h0, u, s, k, k | st[28], k, k | s, 1'b1},
      "mode");
    chk({29'h0, wide_addr_ok, wide_ops_ok, xtlb_refill}, {29'h0,
      k ? st[7] : s ? st[6] : st[5], k | (s ? st[6] : st[5]),
      miss_space == 2'h3 ? st[7] : miss_space == 2'h1 ? st[6] :
      miss_space == 2'h0 ? st[5] : 1'b0},
      "wide");
    chk({30'h0, irq_take, tlb_disabled}, {30'h0, st[0] & !lv &
      (|(p & st[15:8])), st[21]}, "irq");
    @(posedge ref_clk);
  endtask : outs

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [31:0] r, d;
    mr();
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rc(AS, 32'h0040_0004);
    rc(AC, cx());
    outs();
    $display("test reset done");
    w(cpsc_pkg::OFF_COMPARE, 32'hFFFF_0000, 4'hF);
    rc(AC, cx());
    w(cpsc_pkg::OFF_COUNT, 32'hFFFE_FFF8, 4'hF);
    repeat (20) @(posedge ref_clk);
    tp = 1'b1;
    rc(AC, cx());
    $display("test timer done");
    // Random status, cause and pin values; half with interrupts open
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      hw_int_pins <= r[4:0];
      miss_space <= r[6:5];
      d = rnd() & cpsc_pkg::ST_WMASK & ~32'h0200_0000;
      d = d | 32'h0020_0000;
      if (i[0]) d[2:0] = 3'h1;
      w(AS, d, {r[10:8], 1'b1});
      w(AC, rnd(), r[14:11]);
      rc(AS, st);
      rc(AC, cx());
      outs();
    end
    $display("test random done");
    // Every exception code, each followed by a return
    for (int c = 0; c < 14; c++) begin
      r = rnd();
      exc_code_in <= 5'(c);
      exc_in_delay_slot <= r[0];
      exc_cop_num <= r[2:1];
      ev(5'h01);
      st[1] = 1'b1;
      ex = 5'(c);
      sl = r[0];
      if (c == 11) ce = r[2:1];
      rc(AC, cx());
      outs();
      ev(5'h02);
      if (st[2]) st[2] = 1'b0;
      else st[1] = 1'b0;
      rc(AS, st);
    end
    $display("test exceptions done");
    ev(5'h04);
    st = st | 32'h0050_0004;
    rc(AS, st);
    w(AS, 32'h0000_0000, 4'hF);
    ev(5'h08);
    st = st | 32'h0050_0004;
    rc(AS, st);
    ev(5'h10);
    st[21] = 1'b1;
    w(AS, 32'h0000_0000, 4'hF);
    rc(AS, st);
    outs();
    w(8'h10, 32'hFFFF_FFFF, 4'hF);
    rc(8'h10, 32'h0000_0000);
    rc(AS, st);
    // Cold reset in mid run is the only way out of shutdown
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    mr();
    @(posedge ref_clk);
    rc(AS, 32'h0040_0004);
    outs();
    $display("test events done");
    report_and_stop();
  end
endmodule : cp0_status_cause_regs_tb
`default_nettype wire
